/* design/adc_defines.svh */
// Constants for the converter control and serial port block
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    4
`define CONV_NS_PER_CH   550
`define INIT_NS          10000000
`define GRST_NS          1000
// Longest time rounds down, least time rounds up
`define CONV_CYC_PER_CH  ((`CONV_NS_PER_CH) / (`CLK_PERIOD_NS))
`define INIT_CYC         (((`INIT_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define GRST_CYC         (((`GRST_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define TMR_W            22

// ----------------------------------------------------------------
// Span word and packet layout
// ----------------------------------------------------------------
`define SPAN_W           6
`define SPAN_DEFAULT     6'h3F
`define SPAN_CH1_HI      5
`define SPAN_CH1_LO      3
`define SPAN_CH0_HI      2
`define SPAN_CH0_LO      0
`define SPAN_OFF         3'h0
`define CFG_CNT_W        3
`define CFG_WORD_BITS    3'h6
`define RES_W            16
`define PKT_W            24
`define PKT_PAD          4'h0
`define CH_ID0           1'h0
`define CH_ID1           1'h1

// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define APB_AW           12
`define OFS_STATUS       12'h000
`define OFS_RESULT0      12'h004
`define OFS_RESULT1      12'h008
`define OFS_SPAN         12'h00C
`define ST_BUSY          0
`define ST_WINDOW        1
`define ST_NAP           2
`define ST_PDOWN         3
`define ST_GRST          4
`define ST_INIT          5

`endif

/* design/adc_pkg.sv */
// Types shared by the converter control block
package adc_pkg;

  typedef enum logic [2:0] {
    S_GRST,
    S_INIT,
    S_IDLE,
    S_CONV,
    S_NAP
  } ctrl_state_t;

endpackage

/* design/pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,  // System clock
  input  wire logic         rst,      // Async reset, active high
  input  wire logic [W-1:0] pin_in,   // Asynchronous pins
  output logic      [W-1:0] sync_out  // Synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

/* design/span_word_rx.sv */
// Assembles configuration bits into whole span words
`timescale 1ns/10ps
`default_nettype none
`include "adc_defines.svh"

module span_word_rx (
  input  wire logic               sys_clk,    // System clock
  input  wire logic               rst,        // Async reset, active high
  input  wire logic               clear,      // Drops any partial word
  input  wire logic               bit_valid,  // One-cycle bit strobe
  input  wire logic               bit_in,     // Config bit
  output logic                    word_valid, // One-cycle word strobe
  output logic [`SPAN_W-1:0]      word        // Completed word
);

  logic [`SPAN_W-1:0]    shift_r;
  logic [`SPAN_W-1:0]    shift_nxt;
  logic [`CFG_CNT_W-1:0] cnt_r;
  logic [`CFG_CNT_W-1:0] cnt_nxt;
  logic                  done_r;
  logic                  done_nxt;

  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (bit_valid) begin
      shift_nxt = {shift_r[`SPAN_W-2:0], bit_in};
      if (cnt_r == `CFG_WORD_BITS - 3'h1) begin
        cnt_nxt  = '0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
      cnt_r   <= '0;
      done_r  <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  assign word_valid = done_r;
  assign word       = shift_r;

endmodule

`default_nettype wire

/* design/dual_adc_ctrl.sv */
// Conversion sequencing and CMOS serial port of a two-channel converter
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adc_defines.svh"

module dual_adc_ctrl #(
  parameter int unsigned INIT_CYCLES = `INIT_CYC,
  parameter int unsigned GRST_CYCLES = `GRST_CYC
) (
  input  wire logic               sys_clk,           // System clock, 250 MHz
  input  wire logic               rst,               // Power-on reset, active high
  input  wire logic               convert_strobe,    // Convert pin
  input  wire logic               power_down_pin,    // Power-down pin
  input  wire logic               serial_clock_in,   // Host serial clock
  input  wire logic               config_data_in,    // Span config data
  input  wire logic               chip_select_n,     // Port select, active low
  output logic                    busy,              // Conversion in progress
  output logic                    serial_clock_echo, // Echoed clock, half rate
  output logic                    result_lane_zero,  // Data lane zero
  output logic                    result_lane_one,   // Data lane one
  output logic                    serial_out_oe,     // Enable for the three outputs
  input  wire logic               psel,              // APB select
  input  wire logic               penable,           // APB enable
  input  wire logic               pwrite,            // APB direction
  input  wire logic [`APB_AW-1:0] paddr,             // APB byte address
  input  wire logic [31:0]        pwdata,            // APB write data
  output logic      [31:0]        prdata,            // APB read data
  output logic                    pready,            // APB ready
  output logic                    pslverr            // APB error
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`PKT_W-1:0] make_packet(
    input logic [`RES_W-1:0] res,
    input logic              ch_id,
    input logic [2:0]        code
  );
    make_packet = {res, `PKT_PAD, ch_id, code};
  endfunction

  function automatic logic [`TMR_W-1:0] conv_cycles(input logic [`SPAN_W-1:0] span);
    logic [1:0] n;
    n = {1'b0, span[`SPAN_CH0_HI:`SPAN_CH0_LO] != `SPAN_OFF}
      + {1'b0, span[`SPAN_CH1_HI:`SPAN_CH1_LO] != `SPAN_OFF};
    if (n == 2'h0) begin
      n = 2'h1;
    end
    conv_cycles = `TMR_W'(`CONV_CYC_PER_CH) * `TMR_W'(n);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       cnv_s;
  logic       pd_s;
  logic       sck_s;
  logic       sdi_s;
  logic       csn_s;

  pin_sync #(
    .W (5)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   ({convert_strobe, power_down_pin, serial_clock_in,
                config_data_in, chip_select_n}),
    .sync_out (pins_s)
  );

  assign {cnv_s, pd_s, sck_s, sdi_s, csn_s} = pins_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adc_pkg::ctrl_state_t   state_r, state_nxt;
  logic [`TMR_W-1:0]      tmr_r, tmr_nxt;
  logic                   cnv_d_r, cnv_d_nxt;
  logic                   pd_d_r, pd_d_nxt;
  logic                   sck_d_r, sck_d_nxt;
  logic                   busy_r, busy_nxt;
  logic                   win_r, win_nxt;
  logic                   pd_armed_r, pd_armed_nxt;
  logic [`SPAN_W-1:0]     span_r, span_nxt;
  logic [`SPAN_W-1:0]     cap_span_r, cap_span_nxt;
  logic [`RES_W-1:0]      res0_r, res0_nxt;
  logic [`RES_W-1:0]      res1_r, res1_nxt;
  logic [`RES_W-1:0]      cap0_r, cap0_nxt;
  logic [`RES_W-1:0]      cap1_r, cap1_nxt;
  logic [2*`PKT_W-1:0]    lane0_r, lane0_nxt;
  logic [2*`PKT_W-1:0]    lane1_r, lane1_nxt;
  logic                   echo_r, echo_nxt;
  logic                   oe_r, oe_nxt;
  logic [31:0]            prdata_r, prdata_nxt;
  logic                   pready_r, pready_nxt;
  logic                   pslverr_r, pslverr_nxt;

  logic                   cnv_rise;
  logic                   pd_rise;
  logic                   sck_rise;
  logic                   start_ok;
  logic                   word_valid;
  logic [`SPAN_W-1:0]     word;
  logic [`PKT_W-1:0]      pkt0;
  logic [`PKT_W-1:0]      pkt1;

  assign cnv_rise = cnv_s & ~cnv_d_r;
  assign pd_rise  = pd_s & ~pd_d_r;
  assign sck_rise = sck_s & ~sck_d_r;
  // Requests while powered down are dropped, not queued
  assign start_ok = cnv_rise & ~pd_s;

  assign pkt0 = make_packet(cap0_r, `CH_ID0, cap_span_r[`SPAN_CH0_HI:`SPAN_CH0_LO]);
  assign pkt1 = make_packet(cap1_r, `CH_ID1, cap_span_r[`SPAN_CH1_HI:`SPAN_CH1_LO]);

  // ----------------------------------------------------------------
  // Span word receiver
  // ----------------------------------------------------------------
  span_word_rx u_span_rx (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clear      (~win_r),
    .bit_valid  (sck_rise & ~csn_s & win_r),
    .bit_in     (sdi_s),
    .word_valid (word_valid),
    .word       (word)
  );

  // ----------------------------------------------------------------
  // Conversion control and serial port
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_r;
    cnv_d_nxt    = cnv_s;
    pd_d_nxt     = pd_s;
    sck_d_nxt    = sck_s;
    busy_nxt     = busy_r;
    win_nxt      = win_r;
    pd_armed_nxt = pd_armed_r;
    span_nxt     = span_r;
    cap_span_nxt = cap_span_r;
    cap0_nxt     = cap0_r;
    cap1_nxt     = cap1_r;
    lane0_nxt    = lane0_r;
    lane1_nxt    = lane1_r;
    echo_nxt     = echo_r;
    oe_nxt       = ~csn_s;

    if (word_valid && word != '0) begin
      span_nxt = word;
    end

    if (sck_rise && !csn_s) begin
      lane0_nxt = {lane0_r[2*`PKT_W-2:0], lane0_r[2*`PKT_W-1]};
      lane1_nxt = {lane1_r[2*`PKT_W-2:0], lane1_r[2*`PKT_W-1]};
      echo_nxt  = ~echo_r;
    end

    case (state_r)
      adc_pkg::S_GRST: begin
        if (tmr_r == '0) begin
          state_nxt = adc_pkg::S_INIT;
          tmr_nxt   = `TMR_W'(INIT_CYCLES - 1);
        end else begin
          tmr_nxt = tmr_r - `TMR_W'(1);
        end
      end
      adc_pkg::S_INIT, adc_pkg::S_IDLE: begin
        if (start_ok) begin
          state_nxt    = adc_pkg::S_CONV;
          tmr_nxt      = conv_cycles(span_r) - `TMR_W'(1);
          busy_nxt     = 1'b1;
          win_nxt      = 1'b0;
          pd_armed_nxt = 1'b0;
          cap_span_nxt = span_r;
          cap0_nxt     = res0_r;
          cap1_nxt     = res1_r;
        end else if (state_r == adc_pkg::S_INIT) begin
          if (tmr_r == '0) begin
            state_nxt = adc_pkg::S_IDLE;
            win_nxt   = 1'b1;
          end else begin
            tmr_nxt = tmr_r - `TMR_W'(1);
          end
        end
      end
      adc_pkg::S_CONV: begin
        // Power-down does not cut a running conversion short
        if (tmr_r == '0) begin
          busy_nxt  = 1'b0;
          win_nxt   = 1'b1;
          echo_nxt  = 1'b0;
          lane0_nxt = {pkt0, pkt1};
          lane1_nxt = {pkt1, pkt0};
          state_nxt = cnv_s ? adc_pkg::S_NAP : adc_pkg::S_IDLE;
        end else begin
          tmr_nxt = tmr_r - `TMR_W'(1);
        end
      end
      adc_pkg::S_NAP: begin
        // Strobe low leaves nap; the next rise starts from idle
        if (!cnv_s) begin
          state_nxt = adc_pkg::S_IDLE;
        end
      end
      default: begin
        state_nxt = adc_pkg::S_IDLE;
      end
    endcase

    // Global reset overrides everything, including a running conversion
    if (pd_rise) begin
      if (pd_armed_r) begin
        state_nxt    = adc_pkg::S_GRST;
        tmr_nxt      = `TMR_W'(GRST_CYCLES - 1);
        busy_nxt     = 1'b0;
        win_nxt      = 1'b0;
        pd_armed_nxt = 1'b0;
        span_nxt     = `SPAN_DEFAULT;
        lane0_nxt    = '0;
        lane1_nxt    = '0;
        echo_nxt     = 1'b0;
      end else begin
        pd_armed_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r    <= adc_pkg::S_INIT;
      tmr_r      <= `TMR_W'(INIT_CYCLES - 1);
      cnv_d_r    <= 1'b0;
      pd_d_r     <= 1'b0;
      sck_d_r    <= 1'b0;
      busy_r     <= 1'b0;
      win_r      <= 1'b0;
      pd_armed_r <= 1'b0;
      span_r     <= `SPAN_DEFAULT;
      cap_span_r <= `SPAN_DEFAULT;
      cap0_r     <= '0;
      cap1_r     <= '0;
      lane0_r    <= '0;
      lane1_r    <= '0;
      echo_r     <= 1'b0;
      oe_r       <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      tmr_r      <= tmr_nxt;
      cnv_d_r    <= cnv_d_nxt;
      pd_d_r     <= pd_d_nxt;
      sck_d_r    <= sck_d_nxt;
      busy_r     <= busy_nxt;
      win_r      <= win_nxt;
      pd_armed_r <= pd_armed_nxt;
      span_r     <= span_nxt;
      cap_span_r <= cap_span_nxt;
      cap0_r     <= cap0_nxt;
      cap1_r     <= cap1_nxt;
      lane0_r    <= lane0_nxt;
      lane1_r    <= lane1_nxt;
      echo_r     <= echo_nxt;
      oe_r       <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Ready comes one cycle into the access phase; writes land on the edge that ends the ready cycle
  always_comb begin
    res0_nxt    = res0_r;
    res1_nxt    = res1_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt  = psel & penable & ~pready_r;
    if (psel && penable && !pready_r) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == `OFS_STATUS) begin
        prdata_nxt[`ST_BUSY]   = busy_r;
        prdata_nxt[`ST_WINDOW] = win_r;
        prdata_nxt[`ST_NAP]    = state_r == adc_pkg::S_NAP;
        prdata_nxt[`ST_PDOWN]  = pd_s;
        prdata_nxt[`ST_GRST]   = state_r == adc_pkg::S_GRST;
        prdata_nxt[`ST_INIT]   = state_r == adc_pkg::S_INIT;
      end else if (paddr == `OFS_RESULT0) begin
        prdata_nxt[`RES_W-1:0] = res0_r;
      end else if (paddr == `OFS_RESULT1) begin
        prdata_nxt[`RES_W-1:0] = res1_r;
      end else if (paddr == `OFS_SPAN) begin
        prdata_nxt[`SPAN_W-1:0] = span_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (psel && penable && pready_r && pwrite) begin
      if (paddr == `OFS_RESULT0) begin
        res0_nxt = pwdata[`RES_W-1:0];
      end else if (paddr == `OFS_RESULT1) begin
        res1_nxt = pwdata[`RES_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res0_r    <= '0;
      res1_r    <= '0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      res0_r    <= res0_nxt;
      res1_r    <= res1_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy              = busy_r;
  assign serial_clock_echo = echo_r;
  assign result_lane_zero  = lane0_r[2*`PKT_W-1];
  assign result_lane_one   = lane1_r[2*`PKT_W-1];
  assign serial_out_oe     = oe_r;
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;

endmodule

`default_nettype wire

/* testbench/dual_adc_ctrl_props.sv */
// Concurrent checks on the converter control block ports
`timescale 1ns/10ps
`default_nettype none

module dual_adc_ctrl_props (
  input wire logic sys_clk,           // System clock
  input wire logic rst,               // Async reset
  input wire logic convert_strobe,    // Convert pin
  input wire logic power_down_pin,    // Power-down pin
  input wire logic serial_clock_in,   // Host serial clock
  input wire logic chip_select_n,     // Port select
  input wire logic busy,              // Conversion flag
  input wire logic serial_clock_echo, // Echo clock
  input wire logic serial_out_oe,     // Output enable
  input wire logic psel,              // APB select
  input wire logic penable,           // APB enable
  input wire logic pready             // APB ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [9:0] bcnt_r;
  logic [9:0] bcnt_nxt;
  always_comb bcnt_nxt = busy ? bcnt_r + 10'h001 : 10'h000;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) bcnt_r <= 10'h000;
    else bcnt_r <= bcnt_nxt;
  end
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  sequence pd_req_s; power_down_pin[*6] ##0 $rose(convert_strobe); endsequence
  a_busy_limit: assert property (busy |-> bcnt_r < 10'h112)
    else $error("busy held past two channel times");
  a_busy_full: assert property ($fell(busy) && !power_down_pin |-> bcnt_r >= 10'h089)
    else $error("conversion ended early");
  a_start_cause: assert property ($rose(busy) |-> $past(convert_strobe, 2))
    else $error("busy rose without convert strobe");
  a_echo_low: assert property ($fell(busy) |-> !serial_clock_echo)
    else $error("echo not low at busy fall");
  a_oe_off: assert property (chip_select_n[*5] |-> !serial_out_oe)
    else $error("outputs driven while deselected");
  a_echo_cause: assert property ($changed(serial_clock_echo) |-> $fell(busy) || power_down_pin
      || (!chip_select_n && $past(serial_clock_in, 2)))
    else $error("echo moved without serial clock");
  a_pd_ignore: assert property (pd_req_s ##1 !busy |-> !busy[*6])
    else $error("conversion started in power-down");
  a_apb_answer: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held two cycles");
endmodule

bind dual_adc_ctrl dual_adc_ctrl_props u_props (.sys_clk(sys_clk), .rst(rst),
  .convert_strobe(convert_strobe), .power_down_pin(power_down_pin),
  .serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n), .busy(busy),
  .serial_clock_echo(serial_clock_echo), .serial_out_oe(serial_out_oe),
  .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire

/* testbench/host_model.sv */
// Host side of the serial port: clock, select, config bits, lane capture
`timescale 1ns/10ps
`default_nettype none

module host_model (
  output var logic serial_clock_in, // Link clock, runs only in frames
  output var logic config_data_in,  // Span config bit
  output var logic chip_select_n,   // Port select
  input wire logic lane0,           // Resolved lane zero
  input wire logic lane1            // Resolved lane one
);
  initial begin
    serial_clock_in = 1'b0;
    config_data_in = 1'b0;
    chip_select_n = 1'b1;
  end
  // Word goes out MSB first, then CONFIG_DATA_IN idles low so later words are ignored
  task automatic frame(input int n, input logic [5:0] w,
                       output logic [47:0] q0, output logic [47:0] q1);
    q0 = 48'h0;
    q1 = 48'h0;
    chip_select_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      config_data_in = (i < 6) ? w[5-i] : 1'b0;
      #62.5;
      q0 = {q0[46:0], lane0};
      q1 = {q1[46:0], lane1};
      serial_clock_in = 1'b1;
      #62.5;
      serial_clock_in = 1'b0;
    end
    #62.5;
    config_data_in = 1'b0;
    chip_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* testbench/dual_adc_ctrl_test.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none

module dual_adc_ctrl_test;
  localparam int unsigned INIT = 200;
  localparam int unsigned GR = 20;
  localparam int unsigned CPC = 137;
  logic sys_clk = 1'b0, rst = 1'b1, convert_strobe = 1'b0, power_down_pin = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic busy, serial_clock_echo, result_lane_zero, result_lane_one, serial_out_oe;
  logic pready, pslverr, e;
  wire logic serial_clock_in, config_data_in, chip_select_n, lz, lo;
  logic [47:0] q0, q1;
  int errors = 0, cmp_count = 0, bcnt = 0, cyc = 0;
  // Released lanes show a moving pattern, never the last bit
  assign lz = serial_out_oe ? result_lane_zero : sys_clk;
  assign lo = serial_out_oe ? result_lane_one : sys_clk;
  dual_adc_ctrl #(.INIT_CYCLES(INIT), .GRST_CYCLES(GR)) uut (.sys_clk, .rst,
    .convert_strobe, .power_down_pin, .serial_clock_in, .config_data_in, .chip_select_n,
    .busy, .serial_clock_echo, .result_lane_zero, .result_lane_one, .serial_out_oe,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  host_model hm (.serial_clock_in, .config_data_in, .chip_select_n, .lane0(lz), .lane1(lo));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (busy === 1'b1) bcnt <= bcnt + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end
  function automatic logic [23:0] pkt(logic [15:0] r, logic id, logic [2:0] s);
    return {r, 4'h0, id, s};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No local limit: a slave that never answers is caught by the run timeout
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Strobe high 48 ns, or held for nap; optional power-down inside conversion
  task automatic conv(input logic hold, input logic pdm, input int n);
    int k;
    bcnt = 0;
    convert_strobe <= 1'b1;
    repeat (12) @(posedge sys_clk);
    convert_strobe <= hold;
    if (pdm) power_down_pin <= 1'b1;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    @(posedge sys_clk);
    chk(bcnt, n * CPC);
  endtask
  task automatic t_conv();
    apb(1'b1, 12'h004, 32'h0000A5C3);
    apb(1'b1, 12'h008, 32'h00001234);
    apb(1'b0, 12'h010, 32'h0);
    chk({q, e}, 33'h1);
    conv(1'b0, 1'b0, 2);
    rd(12'h000, 32'h02);
    hm.frame(48, 6'b000111, q0, q1);
    chk(q0, {pkt(16'hA5C3, 1'b0, 3'h7), pkt(16'h1234, 1'b1, 3'h7)});
    chk(q1, {pkt(16'h1234, 1'b1, 3'h7), pkt(16'hA5C3, 1'b0, 3'h7)});
    rd(12'h00C, 32'h07);
    conv(1'b0, 1'b0, 1);
    hm.frame(24, 6'h00, q0, q1);
    chk({q0[23:0], q1[23:0]}, {pkt(16'hA5C3, 1'b0, 3'h7), pkt(16'h1234, 1'b1, 3'h0)});
    hm.frame(4, 6'b111000, q0, q1);
    conv(1'b0, 1'b0, 1);
    hm.frame(2, 6'b110000, q0, q1);
    rd(12'h00C, 32'h07);
    $display("conversion test done errors=%0d", errors);
  endtask
  task automatic t_power();
    conv(1'b1, 1'b0, 1);
    rd(12'h000, 32'h06);
    convert_strobe <= 1'b0;
    repeat (190) @(posedge sys_clk);
    conv(1'b0, 1'b0, 1);
    power_down_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(12'h000, 32'h0A);
    conv(1'b0, 1'b0, 0);
    power_down_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    conv(1'b0, 1'b1, 1);
    power_down_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    $display("power test done errors=%0d", errors);
  endtask
  task automatic t_grst();
    bcnt = 0;
    convert_strobe <= 1'b1;
    repeat (12) @(posedge sys_clk);
    convert_strobe <= 1'b0;
    power_down_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    power_down_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    power_down_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({busy, bcnt < CPC}, 2'b01);
    rd(12'h000, 32'h18);
    rd(12'h00C, 32'h3F);
    // Whole word sent while the window is still shut
    hm.frame(6, 6'b001001, q0, q1);
    repeat (GR + INIT + 8) @(posedge sys_clk);
    power_down_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(12'h000, 32'h02);
    hm.frame(24, 6'h00, q0, q1);
    chk({q0[23:0], q1[23:0]}, 48'h0);
    rd(12'h00C, 32'h3F);
    $display("global reset test done errors=%0d", errors);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(12'h000, 32'h20);
    rd(12'h00C, 32'h3F);
    repeat (INIT + 8) @(posedge sys_clk);
    rd(12'h000, 32'h02);
    $display("reset test done errors=%0d", errors);
    t_conv();
    t_power();
    t_grst();
    complete_run();
  end
endmodule
`default_nettype wire
